// File: rtl/tmtwo_pkg.sv
// Contract
// - receive baud comes from this timer's overflows when receive select is 1, else timer 1
// - transmit baud comes from this timer's overflows when transmit select is 1, else timer 1
// - capture select and trigger enable set: falling trigger edge captures the count
// - capture select clear: reload on overflow, and on trigger falls when enabled
// - either clock select set: capture select ignored, reload forced on overflow
// - baud generator mode exists only while receive or transmit select is 1
// - baud mode: high byte rollover reloads the 16-bit count from reload registers
// - serial modes 1 and 3: bit rate is overflow rate divided by 16
// - ordinary timer counts once per machine cycle, one twelfth of oscillator
// - baud mode internal clock counts every state time, half the oscillator
// - baud mode may instead count edges of the external count pin
// - baud mode rollover sets no overflow flag and requests no interrupt
// - baud mode trigger fall sets the external flag but does not reload
// - capture copies low and high count bytes while counting continues
// - external flag and overflow flag both request the one timer interrupt
// - up-count reload mode: overflow past all ones sets flag and reloads
package tmtwo_pkg;
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_CNT_LO  = 8'h04;
    localparam logic [7:0]  ADDR_CNT_HI  = 8'h08;
    localparam logic [7:0]  ADDR_RCAP_LO = 8'h0C;
    localparam logic [7:0]  ADDR_RCAP_HI = 8'h10;
    localparam int          BIT_OVF      = 7;
    localparam int          BIT_EXT      = 6;
    localparam int          BIT_RCLK     = 5;
    localparam int          BIT_TRANSMIT_CLOCK_SELECT     = 4;
    localparam int          BIT_EXEN     = 3;
    localparam int          BIT_RUN      = 2;
    localparam int          BIT_CTSEL    = 1;
    localparam int          BIT_CPRL     = 0;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] RCAP_RST     = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    localparam int          MACHINE_DIV  = 12;
    localparam int          STATE_DIV    = 2;
    localparam logic [3:0]  MACHINE_LAST = 4'(MACHINE_DIV - 1);
    localparam logic [3:0]  STATE_LAST   = 4'(STATE_DIV - 1);
    localparam int          BAUD_DIV     = 16;
    localparam logic [3:0]  BAUD_LAST    = 4'(BAUD_DIV - 1);
    localparam logic [2:0]  PIN_IDLE     = 3'h7;
    typedef enum logic [3:0]
    {
        MODE_OFF     = 4'h1,
        MODE_RELOAD  = 4'h2,
        MODE_CAPTURE = 4'h4,
        MODE_BAUD    = 4'h8
    } tmtwo_mode_type;
endpackage

// File: rtl/tmtwo_evt_if.sv
`timescale 1ns/10ps
interface tmtwo_evt_if;
    logic trig_fall;
    logic cnt_fall;
    logic ovf_pulse;
    modport pins (output trig_fall, output cnt_fall);
    modport core (input trig_fall, input cnt_fall, output ovf_pulse);
    modport baud (input ovf_pulse);
endinterface

// File: rtl/tmtwo_pinsync.sv
`timescale 1ns/10ps
module tmtwo_pinsync
    import tmtwo_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  trig_pin_i,
    input  wire logic  cnt_pin_i,
    tmtwo_evt_if.pins  evt
);
    // [0] first stage, [1] second stage, [2] previous sample
    logic [2:0] trig_q;
    logic [2:0] cnt_q;

    // idle high at reset so release with the pin high fakes no fall; a pin held low at release reads as a fall
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_q <= PIN_IDLE;
            cnt_q  <= PIN_IDLE;
        end
        else
        begin
            trig_q <= {trig_q[1:0], trig_pin_i};
            cnt_q  <= {cnt_q[1:0], cnt_pin_i};
        end
    end

    assign evt.trig_fall = trig_q[2] & ~trig_q[1];
    assign evt.cnt_fall  = cnt_q[2] & ~cnt_q[1];

    property p_fall_single;
        @(posedge clk_i) disable iff (rst_i)
        evt.trig_fall |=> !evt.trig_fall;
    endproperty
    a_fall_single: assert property (p_fall_single) else $error("trigger fall longer than one cycle");
endmodule

// File: rtl/tmtwo_baud.sv
`timescale 1ns/10ps
module tmtwo_baud
    import tmtwo_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        rx_sel_i,
    input  wire logic        tx_sel_i,
    input  wire logic [1:0]  serial_mode_i,
    input  wire logic        timer1_ovf_i,
    tmtwo_evt_if.baud        evt,
    output logic             rx_baud_tick_o,
    output logic             tx_baud_tick_o
);
    logic [3:0] rx_div_q;
    logic [3:0] tx_div_q;
    logic       rx_tick_q;
    logic       tx_tick_q;

    function automatic logic pick_src(input logic sel, input logic own, input logic t1);
        return sel ? own : t1;
    endfunction

    // modes 1 and 3 are the variable-rate ones, odd codes
    wire var_mode = serial_mode_i[0];
    wire rx_src   = var_mode & pick_src(rx_sel_i, evt.ovf_pulse, timer1_ovf_i);
    wire tx_src   = var_mode & pick_src(tx_sel_i, evt.ovf_pulse, timer1_ovf_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_div_q  <= 4'h0;
            tx_div_q  <= 4'h0;
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end
        else
        begin
            rx_div_q  <= rx_div_q + 4'(rx_src);
            tx_div_q  <= tx_div_q + 4'(tx_src);
            rx_tick_q <= rx_src & (rx_div_q == BAUD_LAST);
            tx_tick_q <= tx_src & (tx_div_q == BAUD_LAST);
        end
    end

    assign rx_baud_tick_o = rx_tick_q;
    assign tx_baud_tick_o = tx_tick_q;

    property p_rx_div;
        @(posedge clk_i) disable iff (rst_i)
        rx_baud_tick_o |-> $past(rx_src) && $past(rx_div_q) == BAUD_LAST;
    endproperty
    a_rx_div: assert property (p_rx_div) else $error("receive tick not on sixteenth source");

    property p_tx_own;
        @(posedge clk_i) disable iff (rst_i)
        tx_sel_i && var_mode && evt.ovf_pulse |=> tx_div_q == $past(tx_div_q) + 4'h1;
    endproperty
    a_tx_own: assert property (p_tx_own) else $error("transmit divider ignored own overflow");

    c_rx_tick: cover property (@(posedge clk_i) disable iff (rst_i) rx_baud_tick_o);
endmodule

// File: rtl/tmtwo_top.sv
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module tmtwo_top
    import tmtwo_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        trig_pin_i,
    input  wire logic        cnt_pin_i,
    input  wire logic        timer1_ovf_i,
    input  wire logic [1:0]  serial_mode_i,
    output logic             timer_irq_o,
    output logic             rx_baud_tick_o,
    output logic             tx_baud_tick_o
);
    logic        ovf_q;
    logic        ext_q;
    logic        rclk_q;
    logic        transmit_clock_select_q;
    logic        exen_q;
    logic        run_q;
    logic        ctsel_q;
    logic        cprl_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] rcap_q;
    logic [15:0] rcap_d;
    logic [3:0]  pre_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        irq_q;
    logic        ovf_d;
    logic        ext_d;
    logic        reload_ev;
    logic        set_ovf;
    tmtwo_mode_type mode;

    tmtwo_evt_if evt ();

    tmtwo_pinsync u_pins
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .trig_pin_i (trig_pin_i),
        .cnt_pin_i  (cnt_pin_i),
        .evt        (evt.pins)
    );

    tmtwo_baud u_baud
    (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .rx_sel_i       (rclk_q),
        .tx_sel_i       (transmit_clock_select_q),
        .serial_mode_i  (serial_mode_i),
        .timer1_ovf_i   (timer1_ovf_i),
        .evt            (evt.baud),
        .rx_baud_tick_o (rx_baud_tick_o),
        .tx_baud_tick_o (tx_baud_tick_o)
    );

    // bus decode; one wait state, answer registered
    wire wb_req      = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr_lane     = wb_req & wb_we_i & wb_sel_i[0];
    wire wr_ctrl     = wr_lane & (wb_adr_i == ADDR_CTRL);
    wire wr_cnt_lo   = wr_lane & (wb_adr_i == ADDR_CNT_LO);
    wire wr_cnt_hi   = wr_lane & (wb_adr_i == ADDR_CNT_HI);
    wire wr_rcap_lo  = wr_lane & (wb_adr_i == ADDR_RCAP_LO);
    wire wr_rcap_hi  = wr_lane & (wb_adr_i == ADDR_RCAP_HI);
    wire wr_cnt_any  = wr_cnt_lo | wr_cnt_hi;
    wire wr_rcap_any = wr_rcap_lo | wr_rcap_hi;
    wire [7:0] wbyte = wb_dat_i[7:0];

    wire [7:0] ctrl_rd = {ovf_q, ext_q, rclk_q, transmit_clock_select_q, exen_q, run_q, ctsel_q, cprl_q};
    wire [7:0] rd_byte =
        (wb_adr_i == ADDR_CTRL)    ? ctrl_rd      :
        (wb_adr_i == ADDR_CNT_LO)  ? cnt_q[7:0]   :
        (wb_adr_i == ADDR_CNT_HI)  ? cnt_q[15:8]  :
        (wb_adr_i == ADDR_RCAP_LO) ? rcap_q[7:0]  :
        (wb_adr_i == ADDR_RCAP_HI) ? rcap_q[15:8] : 8'h00;

    // mode decode
    wire baud_mode = rclk_q | transmit_clock_select_q;
    assign mode = !run_q    ? MODE_OFF     :
                  baud_mode ? MODE_BAUD    :
                  cprl_q    ? MODE_CAPTURE : MODE_RELOAD;

    // count source: prescaled oscillator or external pin edges
    wire [3:0] pre_last = baud_mode ? STATE_LAST : MACHINE_LAST;
    wire pre_hit  = pre_q >= pre_last;
    // a mode switch while running restarts the prescaler, no stale early tick
    wire pre_restart = wr_ctrl & ((wbyte[BIT_RCLK] | wbyte[BIT_TRANSMIT_CLOCK_SELECT]) != baud_mode);
    wire tick     = run_q & (ctsel_q ? evt.cnt_fall : pre_hit);
    wire roll     = tick & (cnt_q == CNT_MAX);
    wire trig_ev  = exen_q & evt.trig_fall;
    // trigger acts on the registers even while stopped, like the flag
    wire capture_ev  = trig_ev & ~baud_mode & cprl_q;
    wire trig_reload = trig_ev & ~baud_mode & ~cprl_q;

    assign evt.ovf_pulse = roll;

    always_comb
    begin
        reload_ev = 1'b0;
        set_ovf   = 1'b0;
        unique case (mode)
            MODE_OFF:
            begin
                reload_ev = trig_reload;
            end
            MODE_RELOAD:
            begin
                reload_ev = roll | trig_reload;
                set_ovf   = roll;
            end
            MODE_CAPTURE:
            begin
                set_ovf   = roll;
            end
            MODE_BAUD:
            begin
                reload_ev = roll;
            end
            default:
            begin
                reload_ev = 1'b0;
            end
        endcase
    end

    // software write wins over counting; bench must follow the stop-first rule
    always_comb
    begin
        cnt_d = cnt_q;
        if (wr_cnt_lo)
            cnt_d = {cnt_q[15:8], wbyte};
        else if (wr_cnt_hi)
            cnt_d = {wbyte, cnt_q[7:0]};
        else if (reload_ev)
            cnt_d = rcap_q;
        else if (tick)
            cnt_d = cnt_q + 16'h0001;
    end

    always_comb
    begin
        rcap_d = rcap_q;
        if (wr_rcap_lo)
            rcap_d = {rcap_q[15:8], wbyte};
        else if (wr_rcap_hi)
            rcap_d = {wbyte, rcap_q[7:0]};
        else if (capture_ev)
            rcap_d = cnt_q;
    end

    // hardware set beats a software clear in the same cycle
    assign ovf_d = set_ovf | (wr_ctrl ? wbyte[BIT_OVF] : ovf_q);
    assign ext_d = trig_ev | (wr_ctrl ? wbyte[BIT_EXT] : ext_q);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {ovf_q, ext_q, rclk_q, transmit_clock_select_q, exen_q, run_q, ctsel_q, cprl_q} <= CTRL_RST;
            cnt_q  <= CNT_RST;
            rcap_q <= RCAP_RST;
            pre_q  <= 4'h0;
            irq_q  <= 1'b0;
        end
        else
        begin
            ovf_q  <= ovf_d;
            ext_q  <= ext_d;
            if (wr_ctrl)
            begin
                rclk_q  <= wbyte[BIT_RCLK];
                transmit_clock_select_q  <= wbyte[BIT_TRANSMIT_CLOCK_SELECT];
                exen_q  <= wbyte[BIT_EXEN];
                run_q   <= wbyte[BIT_RUN];
                ctsel_q <= wbyte[BIT_CTSEL];
                cprl_q  <= wbyte[BIT_CPRL];
            end
            cnt_q  <= cnt_d;
            rcap_q <= rcap_d;
            pre_q  <= (!run_q || pre_hit || pre_restart) ? 4'h0 : pre_q + 4'h1;
            irq_q  <= ovf_d | ext_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q  <= wb_req;
            rdat_q <= wb_req ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdat_q;
    assign timer_irq_o = irq_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_baud_no_flag;
        roll && baud_mode && !ovf_q && !wr_ctrl |=> !ovf_q;
    endproperty
    a_baud_no_flag: assert property (p_baud_no_flag) else $error("baud rollover set flag");

    property p_reload_ovf;
        mode == MODE_RELOAD && roll && !wr_cnt_any && !wr_rcap_any
            |=> ovf_q && cnt_q == $past(rcap_q);
    endproperty
    a_reload_ovf: assert property (p_reload_ovf) else $error("overflow reload missed");

    property p_baud_reload;
        mode == MODE_BAUD && roll && !wr_cnt_any |=> cnt_q == $past(rcap_q);
    endproperty
    a_baud_reload: assert property (p_baud_reload) else $error("baud reload missed");

    property p_capture;
        capture_ev && !wr_rcap_any && !wr_cnt_any && !reload_ev
            |=> rcap_q == $past(cnt_q) && cnt_q == $past(cnt_q) + 16'($past(tick));
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost or count stopped");

    property p_baud_trig;
        trig_ev && baud_mode && !tick && !wr_cnt_any |=> cnt_q == $past(cnt_q) && ext_q;
    endproperty
    a_baud_trig: assert property (p_baud_trig) else $error("baud trigger reloaded");

    property p_force_reload;
        baud_mode && cprl_q && trig_ev && !wr_rcap_any |=> rcap_q == $past(rcap_q);
    endproperty
    a_force_reload: assert property (p_force_reload) else $error("capture in baud mode");

    property p_trig_off;
        !exen_q && !ext_q && !wr_ctrl |=> !ext_q;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("flag set with trigger disabled");

    property p_machine_rate;
        tick && !ctsel_q && !baud_mode |-> pre_q == MACHINE_LAST;
    endproperty
    a_machine_rate: assert property (p_machine_rate) else $error("timer tick off twelfth");

    property p_state_rate;
        tick && !ctsel_q && baud_mode |-> pre_q == STATE_LAST;
    endproperty
    a_state_rate: assert property (p_state_rate) else $error("baud tick off half rate");

    property p_irq;
        $rose(ext_q) |-> timer_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("external flag gave no interrupt");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request left unanswered");

    property p_rdat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_rdat_idle: assert property (p_rdat_idle) else $error("read data outside ack");

    property p_trig_flag;
        trig_ev |=> ext_q && timer_irq_o;
    endproperty
    a_trig_flag: assert property (p_trig_flag) else $error("trigger fall left flag clear");

    property p_capture_wrap;
        mode == MODE_CAPTURE && roll && !wr_cnt_any |=> ovf_q && cnt_q == 16'h0000;
    endproperty
    a_capture_wrap: assert property (p_capture_wrap) else $error("capture overflow wrong");

    property p_pre_restart;
        $changed(baud_mode) && run_q |-> pre_q == 4'h0;
    endproperty
    a_pre_restart: assert property (p_pre_restart) else $error("prescaler kept old phase");

    c_ext_count: cover property (tick && ctsel_q && baud_mode);
    c_baud_roll: cover property (roll && baud_mode);
    c_capture:   cover property (capture_ev);
    c_trig_rld:  cover property (trig_reload && run_q);
endmodule

// File: dv/tmtwo_serial_model.sv
`timescale 1ns/10ps
module tmtwo_serial_model
#(
    parameter int T1_PERIOD = 20
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        clr_i,
    input  wire logic        rx_baud_tick_i,
    input  wire logic        tx_baud_tick_i,
    output logic             timer1_ovf_o,
    output logic      [15:0] rx_cnt_o,
    output logic      [15:0] tx_cnt_o
);
    logic [7:0] t1_q;
    wire        t1_wrap = (t1_q == 8'(T1_PERIOD - 1));

    // timer 1 stand-in: a fixed overflow rate so the fallback source is predictable
    always_ff @(posedge clk_i)
    begin
        if (rst_i || t1_wrap)
            t1_q <= 8'h00;
        else
            t1_q <= t1_q + 8'h01;
    end
    assign timer1_ovf_o = t1_wrap;

    // shifters reduced to bit clock counters; framing is not modelled
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clr_i)
        begin
            rx_cnt_o <= 16'h0000;
            tx_cnt_o <= 16'h0000;
        end
        else
        begin
            rx_cnt_o <= rx_cnt_o + 16'(rx_baud_tick_i);
            tx_cnt_o <= tx_cnt_o + 16'(tx_baud_tick_i);
        end
    end
endmodule

// File: dv/tmtwo_top_tb_top.sv
`timescale 1ns/10ps
module tmtwo_top_tb_top
    import tmtwo_pkg::*;
;
    localparam int T1_PERIOD = 20;
    localparam int WIN       = 1280;
    logic        clk_i, rst_i, cyc, stb, we, trig, cpin, clr;
    logic [7:0]  adr, rd;
    logic [3:0]  sel;
    logic [31:0] dat, wb_dat_o;
    logic        wb_ack_o, irq, rx_tick, tx_tick, t1_ovf;
    logic [1:0]  smode;
    logic [15:0] rx_cnt, tx_cnt, r16;
    logic [7:0]  ctls [4] = '{8'h35, 8'h25, 8'h15, 8'h35};
    int          n_mismatch, cmp_count, cyc_count;

    tmtwo_top tmtwo_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .trig_pin_i(trig), .cnt_pin_i(cpin), .timer1_ovf_i(t1_ovf),
        .serial_mode_i(smode), .timer_irq_o(irq), .rx_baud_tick_o(rx_tick),
        .tx_baud_tick_o(tx_tick));
    tmtwo_serial_model #(.T1_PERIOD(T1_PERIOD)) tmtwo_serial_model_inst (.clk_i(clk_i),
        .rst_i(rst_i), .clr_i(clr), .rx_baud_tick_i(rx_tick), .tx_baud_tick_i(tx_tick),
        .timer1_ovf_o(t1_ovf), .rx_cnt_o(rx_cnt), .tx_cnt_o(tx_cnt));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // the whole run needs about 5600 cycles
    always @(posedge clk_i)
    begin
        cyc_count++;
        if (cyc_count == 20000)
        begin
            n_mismatch++;
            $display("unexpected at %0t: bench timeout", $time);
            results();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // rate checks allow one step of prescaler phase either way
    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        cmp_count++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h000000, d};
        // no local limit: only the bench timeout ends a wait
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk8(rd, exp);
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wb(1'b1, a, v[7:0]);
        wb(1'b1, a + 8'h04, v[15:8]);
    endtask

    task automatic rd16(input logic [7:0] a);
        wb(1'b0, a, 8'h00);
        r16[7:0] = rd;
        wb(1'b0, a + 8'h04, 8'h00);
        r16[15:8] = rd;
    endtask

    // pins held well past the two-cycle minimum
    task automatic fall(input logic on_cnt);
        @(posedge clk_i);
        if (on_cnt)
            cpin <= 1'b0;
        else
            trig <= 1'b0;
        repeat (4) @(posedge clk_i);
        cpin <= 1'b1;
        trig <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    initial
    begin
        int e;
        rst_i = 1'b1;
        {cyc, stb, we, clr} = 4'h0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h00000000;
        trig = 1'b1;
        cpin = 1'b1;
        smode = 2'h1;
        n_mismatch = 0;
        cmp_count = 0;
        cyc_count = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++)
            rchk(8'(i * 4), 8'h00);
        wr16(ADDR_RCAP_LO, 16'h1234);
        wr16(ADDR_CNT_LO, 16'hFFFE);
        wb(1'b1, ADDR_CTRL, 8'h04);
        repeat (60) @(posedge clk_i);
        rchk(ADDR_CTRL, 8'h84);
        chk8({7'h00, irq}, 8'h01);
        wb(1'b1, ADDR_CTRL, 8'h00);
        chk8({7'h00, irq}, 8'h00);
        rd16(ADDR_CNT_LO);
        chk_rng(r16, 16'h1235, 16'h1238);
        wr16(ADDR_CNT_LO, 16'h0000);
        wb(1'b1, ADDR_CTRL, 8'h04);
        repeat (120) @(posedge clk_i);
        wb(1'b1, ADDR_CTRL, 8'h00);
        rd16(ADDR_CNT_LO);
        chk_rng(r16, 16'h0009, 16'h000B);
        wr16(ADDR_CNT_LO, 16'hABCD);
        wb(1'b1, ADDR_CTRL, 8'h09);
        fall(1'b0);
        rd16(ADDR_RCAP_LO);
        chk_rng(r16, 16'hABCD, 16'hABCD);
        rchk(ADDR_CTRL, 8'h49);
        chk8({7'h00, irq}, 8'h01);
        rd16(ADDR_CNT_LO);
        chk_rng(r16, 16'hABCD, 16'hABCD);
        wb(1'b1, ADDR_CTRL, 8'h01);
        wr16(ADDR_CNT_LO, 16'h5555);
        fall(1'b0);
        rchk(ADDR_CTRL, 8'h01);
        rd16(ADDR_RCAP_LO);
        chk_rng(r16, 16'hABCD, 16'hABCD);
        wb(1'b1, ADDR_CTRL, 8'h08);
        fall(1'b0);
        rd16(ADDR_CNT_LO);
        chk_rng(r16, 16'hABCD, 16'hABCD);
        rchk(ADDR_CTRL, 8'h48);
        wb(1'b1, ADDR_CTRL, 8'h00);
        wr16(ADDR_RCAP_LO, 16'hFF00);
        wr16(ADDR_CNT_LO, 16'h4321);
        wb(1'b1, ADDR_CTRL, 8'h3E);
        fall(1'b0);
        repeat (4) fall(1'b1);
        rchk(ADDR_CTRL, 8'h7E);
        wb(1'b1, ADDR_CTRL, 8'h00);
        rd16(ADDR_CNT_LO);
        chk_rng(r16, 16'h4325, 16'h4325);
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, ADDR_CTRL, 8'h00);
            wr16(ADDR_RCAP_LO, 16'hFFFC);
            wr16(ADDR_CNT_LO, 16'hFFFC);
            smode <= (i == 3) ? 2'h2 : 2'h1;
            wb(1'b1, ADDR_CTRL, ctls[i]);
            @(posedge clk_i);
            clr <= 1'b1;
            @(posedge clk_i);
            clr <= 1'b0;
            repeat (WIN) @(posedge clk_i);
            e = (i == 3) ? 0 : (ctls[i][BIT_RCLK] ? WIN / 128 : WIN / (16 * T1_PERIOD));
            chk_rng(rx_cnt, 16'((e > 0) ? e - 1 : 0), 16'((e > 0) ? e + 1 : 0));
            e = (i == 3) ? 0 : (ctls[i][BIT_TRANSMIT_CLOCK_SELECT] ? WIN / 128 : WIN / (16 * T1_PERIOD));
            chk_rng(tx_cnt, 16'((e > 0) ? e - 1 : 0), 16'((e > 0) ? e + 1 : 0));
            rchk(ADDR_CTRL, ctls[i]);
            chk8({7'h00, irq}, 8'h00);
        end
        results();
    end
endmodule
